/* File: rtl/mtg_trigger_gate.sv */
// trigger, pacing and chain sync control for measured-value output
//
// Overview of operation
// - in edge mode each rising trigger edge sends exactly one value per channel.
// - edges faster than the data rate resend the latest converted values.
// - in level mode values go out at the data rate while the trigger is high.
// - in gate mode each rising edge toggles sending at the data rate on or off.
// - a software single shot sends one value per channel in any mode.
// - the chain holds at most nine controllers on one timing, positions 0 to 8.
// - sampling timing comes from the channel 1 demodulator, which must be present.
// - all channels are captured on the same sampling instant.
// - a live sync input slaves local timing to the upstream controller.
// - with no sync input activity the controller is the timing master.
//
// The plain strobed port and the placing of the registers were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "mtg_consts.svh"
module mtg_trigger_gate
    import mtg_pkg::*;
#(
    parameter int CHANNELS = 8,
    parameter int WIDTH    = 24,
    parameter int CHAIN_POS = 0
)
(
    // clock and reset
    input  wire logic                      clk_sys,
    input  wire logic                      sys_rst,
    // register port
    input  wire logic [3:0]                regAddr,
    input  wire logic [31:0]               regWdata,
    input  wire logic                      regWr,
    input  wire logic                      regRd,
    output var  logic [31:0]               regRdata,
    // pins
    input  wire logic                      trigPin,
    input  wire logic                      syncInPin,
    output var  logic                      syncOutPin,
    // converter side
    input  wire logic                      demodPresent,
    input  wire logic [CHANNELS*WIDTH-1:0] convData,
    // stream out
    output var  logic                      sendValid,
    output var  logic [CHANNELS*WIDTH-1:0] sendData,
    output var  logic                      sendDup
);
    localparam int IW = $clog2(CHANNELS);

    // ************************************************************
    // state
    // ************************************************************
    mtg_bus_t                bus;
    mtg_mode_t               mode_ff, nxt_mode;
    logic                    en_ff, nxt_en;
    logic [31:0]             rate_ff, nxt_rate;
    logic [31:0]             div_ff, nxt_div;
    logic                    tick_ff, nxt_tick;
    logic                    gate_ff, nxt_gate;
    logic                    pend_ff, nxt_pend;
    logic                    shot_ff, nxt_shot;
    logic                    fresh_ff, nxt_fresh;
    logic                    trigLast_ff, nxt_trigLast;
    logic                    syncLast_ff, nxt_syncLast;
    logic [15:0]             syncAge_ff, nxt_syncAge;
    logic                    slave_ff, nxt_slave;
    logic                    syncOut_ff, nxt_syncOut;
    logic                    valid_ff, nxt_valid;
    logic                    dup_ff, nxt_dup;
    logic [CHANNELS*WIDTH-1:0] data_ff, nxt_data;
    logic [CHANNELS*WIDTH-1:0] latest_ff, nxt_latest;
    logic [31:0]             cnt_ff, nxt_cnt;
    logic [31:0]             rd_ff, nxt_rd;
    logic                    rdMem_ff, nxt_rdMem;
    logic                    trigLvl, syncLvl;
    logic                    trigRise, syncEdge, sample, fire;
    logic [WIDTH-1:0]        memData;
    logic [CHANNELS*WIDTH-1:0] memLatest;

    assign bus = '{wr: regWr, rd: regRd, addr: regAddr, wdata: regWdata};

    function automatic logic rising(input logic now, input logic last);
        rising = now & ~last;
    endfunction

    // ************************************************************
    // pin synchronisers and sample store
    // ************************************************************
    mtg_sync3 uTrigSync
    (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .pinIn   (trigPin),
        .levelOut(trigLvl)
    );

    mtg_sync3 uSyncSync
    (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .pinIn   (syncInPin),
        .levelOut(syncLvl)
    );

    // latest converted values, all channels at once
    mtg_sample_mem #(.CHANNELS(CHANNELS), .WIDTH(WIDTH)) uMem
    (
        .clk_sys(clk_sys),
        .wrAll  (sample),
        .wrData (convData),
        .rdIdx  (bus.addr[IW-1:0]),
        .rdData (memData)
    );

    // ************************************************************
    // timing: local divider or upstream sync
    // ************************************************************
    assign trigRise = rising(trigLvl, trigLast_ff);
    // upstream toggles once per instant, so both edges count
    assign syncEdge = syncLvl ^ syncLast_ff;
    // no sampling without the channel 1 demodulator
    assign sample   = demodPresent & (slave_ff ? syncEdge : tick_ff);

    // divider tick, sync age and sync forward
    always_comb
    begin
        nxt_trigLast = trigLvl;
        nxt_syncLast = syncLvl;
        nxt_tick     = 1'b0;
        nxt_div      = div_ff + 32'h0000_0001;
        if (div_ff >= rate_ff)
        begin
            nxt_div  = 32'h0000_0000;
            nxt_tick = 1'b1;
        end
        // sync input activity ages out to master
        nxt_syncAge = (syncAge_ff == `MTG_SYNC_TIMEOUT) ? syncAge_ff : syncAge_ff + 16'h0001;
        if (syncEdge)
            nxt_syncAge = 16'h0000;
        nxt_slave   = (syncAge_ff != `MTG_SYNC_TIMEOUT);
        // forward the timing downstream
        nxt_syncOut = sample ? ~syncOut_ff : syncOut_ff;
        if (CHAIN_POS >= `MTG_MAX_CHAIN)
            nxt_syncOut = 1'b0;
    end

    // ************************************************************
    // trigger modes and send decision
    // ************************************************************
    // register writes, mode decode and fire
    always_comb
    begin
        nxt_mode  = mode_ff;
        nxt_en    = en_ff;
        nxt_rate  = rate_ff;
        nxt_shot  = 1'b0;
        nxt_gate  = gate_ff;
        nxt_pend  = pend_ff;
        nxt_fresh = fresh_ff | sample;
        fire      = 1'b0;
        if (bus.wr && bus.addr == `MTG_ADDR_CTRL)
        begin
            nxt_mode = mtg_mode_t'(bus.wdata[`MTG_CTRL_MODE_LSB +: 2]);
            nxt_en   = bus.wdata[`MTG_CTRL_EN_BIT];
        end
        if (bus.wr && bus.addr == `MTG_ADDR_RATE)
            nxt_rate = bus.wdata;
        if (bus.wr && bus.addr == `MTG_ADDR_CMD)
            nxt_shot = bus.wdata[`MTG_CMD_SHOT_BIT];
        unique case (mode_ff)
            MTG_MODE_OFF:
                fire = 1'b0;
            MTG_MODE_EDGE:
            begin
                nxt_pend = pend_ff | (trigRise & en_ff);
                fire     = en_ff & pend_ff;
                if (fire)
                    nxt_pend = trigRise;
            end
            MTG_MODE_LEVEL:
                fire = en_ff & trigLvl & sample;
            MTG_MODE_GATE:
            begin
                if (trigRise && en_ff)
                    nxt_gate = ~gate_ff;
                fire = en_ff & gate_ff & sample;
            end
        endcase
        if (shot_ff)
            fire = 1'b1;
        // a send uses up any fresh sample
        if (fire)
            nxt_fresh = 1'b0;
        // mode change clears gate and pending edge
        if (nxt_mode != mode_ff)
        begin
            nxt_gate = 1'b0;
            nxt_pend = 1'b0;
        end
    end

    // ************************************************************
    // output stream and register read
    // ************************************************************
    assign memLatest = sample ? convData : latest_ff;

    // send register, latest set and read mux
    always_comb
    begin
        nxt_valid  = fire;
        nxt_data   = data_ff;
        nxt_dup    = dup_ff;
        nxt_cnt    = cnt_ff;
        // latest set, all channels from one instant
        nxt_latest = memLatest;
        if (fire)
        begin
            nxt_data = memLatest;
            nxt_dup  = ~(fresh_ff | sample);
            nxt_cnt  = cnt_ff + 32'h0000_0001;
        end
        nxt_rdMem = bus.rd && bus.addr[`MTG_SAMPLE_SEL_BIT];
        nxt_rd    = 32'h0000_0000;
        if (bus.rd)
        begin
            unique case (bus.addr)
                `MTG_ADDR_CTRL:   nxt_rd = {29'h0, en_ff, mode_ff};
                `MTG_ADDR_RATE:   nxt_rd = rate_ff;
                `MTG_ADDR_STATUS: nxt_rd = {27'h0, demodPresent, slave_ff, pend_ff, gate_ff, dup_ff};
                `MTG_ADDR_COUNT:  nxt_rd = cnt_ff;
                default:          nxt_rd = 32'h0000_0000;
            endcase
        end
    end

    // register all control and stream state
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            mode_ff     <= MTG_MODE_OFF;
            en_ff       <= 1'b0;
            rate_ff     <= `MTG_RATE_RESET;
            div_ff      <= 32'h0000_0000;
            tick_ff     <= 1'b0;
            gate_ff     <= 1'b0;
            pend_ff     <= 1'b0;
            shot_ff     <= 1'b0;
            fresh_ff    <= 1'b0;
            trigLast_ff <= 1'b0;
            syncLast_ff <= 1'b0;
            syncAge_ff  <= `MTG_SYNC_TIMEOUT;
            slave_ff    <= 1'b0;
            syncOut_ff  <= 1'b0;
            valid_ff    <= 1'b0;
            dup_ff      <= 1'b0;
            data_ff     <= '0;
            latest_ff   <= '0;
            cnt_ff      <= 32'h0000_0000;
            rd_ff       <= 32'h0000_0000;
            rdMem_ff    <= 1'b0;
        end
        else
        begin
            mode_ff     <= nxt_mode;
            en_ff       <= nxt_en;
            rate_ff     <= nxt_rate;
            div_ff      <= nxt_div;
            tick_ff     <= nxt_tick;
            gate_ff     <= nxt_gate;
            pend_ff     <= nxt_pend;
            shot_ff     <= nxt_shot;
            fresh_ff    <= nxt_fresh;
            trigLast_ff <= nxt_trigLast;
            syncLast_ff <= nxt_syncLast;
            syncAge_ff  <= nxt_syncAge;
            slave_ff    <= nxt_slave;
            syncOut_ff  <= nxt_syncOut;
            valid_ff    <= nxt_valid;
            dup_ff      <= nxt_dup;
            data_ff     <= nxt_data;
            latest_ff   <= nxt_latest;
            cnt_ff      <= nxt_cnt;
            rd_ff       <= nxt_rd;
            rdMem_ff    <= nxt_rdMem;
        end
    end

    // memory reads return zero; the store's own register output is not used
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            regRdata <= 32'h0000_0000;
        else
            regRdata <= nxt_rdMem ? 32'h0000_0000 : nxt_rd;
    end

    assign syncOutPin = syncOut_ff;
    assign sendValid  = valid_ff;
    assign sendData   = data_ff;
    assign sendDup    = dup_ff;
endmodule
`default_nettype wire

/* File: rtl/mtg_consts.svh */
// constants for the measurement trigger gate
`ifndef MTG_CONSTS_SVH
`define MTG_CONSTS_SVH
`define MTG_ADDR_CTRL     4'h0
`define MTG_ADDR_RATE     4'h1
`define MTG_ADDR_CMD      4'h2
`define MTG_ADDR_STATUS   4'h3
`define MTG_ADDR_COUNT    4'h4
`define MTG_ADDR_SAMPLE   4'h8
`define MTG_SAMPLE_SEL_BIT 3
`define MTG_CTRL_EN_BIT   2
`define MTG_CTRL_MODE_LSB 0
`define MTG_CMD_SHOT_BIT  0
`define MTG_RATE_RESET    32'h0000_0064
`define MTG_MAX_CHAIN     8
`define MTG_SYNC_TIMEOUT  16'h0100
`endif

/* File: rtl/mtg_pkg.sv */
// types for the measurement trigger gate
package mtg_pkg;
    typedef enum logic [1:0] {MTG_MODE_OFF, MTG_MODE_EDGE, MTG_MODE_LEVEL, MTG_MODE_GATE} mtg_mode_t;
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [3:0]  addr;
        logic [31:0] wdata;
    } mtg_bus_t;
endpackage

/* File: rtl/mtg_sync3.sv */
// three-stage input synchroniser with agreement check
`timescale 1ns/1ns
`default_nettype none
module mtg_sync3
(
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic sys_rst,
    // pin in, clean level out
    input  wire logic pinIn,
    output var  logic levelOut
);
    logic [2:0] stage_ff;
    logic [2:0] nxt_stage;
    logic       level_ff;
    logic       nxt_level;

    // shift and accept when stages two and three agree
    always_comb
    begin
        nxt_stage = {stage_ff[1:0], pinIn};
        nxt_level = (stage_ff[2] == stage_ff[1]) ? stage_ff[2] : level_ff;
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            stage_ff <= 3'h0;
            level_ff <= 1'b0;
        end
        else
        begin
            stage_ff <= nxt_stage;
            level_ff <= nxt_level;
        end
    end

    assign levelOut = level_ff;
endmodule
`default_nettype wire

/* File: rtl/mtg_sample_mem.sv */
// per-channel sample store with registered read
`timescale 1ns/1ns
`default_nettype none
module mtg_sample_mem
#(
    parameter int CHANNELS = 8,
    parameter int WIDTH    = 24
)
(
    // clock
    input  wire logic                        clk_sys,
    // write side, all channels at once
    input  wire logic                        wrAll,
    input  wire logic [CHANNELS*WIDTH-1:0]   wrData,
    // read side
    input  wire logic [$clog2(CHANNELS)-1:0] rdIdx,
    output var  logic [WIDTH-1:0]            rdData
);
    logic [WIDTH-1:0] mem_ff [CHANNELS];
    logic [WIDTH-1:0] rd_ff;

    // capture every channel on the same edge
    always_ff @(posedge clk_sys)
    begin
        for (int i = 0; i < CHANNELS; i++)
        begin
            if (wrAll)
                mem_ff[i] <= wrData[i*WIDTH +: WIDTH];
        end
        rd_ff <= mem_ff[rdIdx];
    end

    assign rdData = rd_ff;
endmodule
`default_nettype wire

/* File: verif/mtg_gate_sva.sv */
// assertion checker for the trigger gate ports
`timescale 1ns/1ns
`default_nettype none
`include "mtg_consts.svh"
module mtg_gate_sva
    import mtg_pkg::*;
#(
    parameter int CHANNELS  = 8,
    parameter int WIDTH     = 24,
    parameter int CHAIN_POS = 0
)
(
    // clock, reset and register port
    input wire logic                      clk_sys,
    input wire logic                      sys_rst,
    input wire logic [3:0]                regAddr,
    input wire logic [31:0]               regWdata,
    input wire logic                      regWr,
    input wire logic                      regRd,
    input wire logic [31:0]               regRdata,
    // pins, converter and stream
    input wire logic                      trigPin,
    input wire logic                      syncInPin,
    input wire logic                      syncOutPin,
    input wire logic                      demodPresent,
    input wire logic [CHANNELS*WIDTH-1:0] convData,
    input wire logic                      sendValid,
    input wire logic [CHANNELS*WIDTH-1:0] sendData,
    input wire logic                      sendDup
);
    // ****************
    // helper and rules
    // ****************
    logic [2:0] ctrl_ff, nxt_ctrl;
    logic [3:0] quiet_ff, nxt_quiet;
    // shadow of mode, cycles since a control or command write
    always_comb
    begin
        nxt_ctrl  = regWr && regAddr == `MTG_ADDR_CTRL ? regWdata[2:0] : ctrl_ff;
        nxt_quiet = quiet_ff == 4'hF ? quiet_ff : quiet_ff + 4'h1;
        if (regWr && (regAddr == `MTG_ADDR_CTRL || regAddr == `MTG_ADDR_CMD))
            nxt_quiet = 4'h0;
    end
    always_ff @(posedge clk_sys)
    begin
        ctrl_ff  <= sys_rst ? 3'h0 : nxt_ctrl;
        quiet_ff <= sys_rst ? 4'h0 : nxt_quiet;
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    sequence shotWr;
        regWr && regAddr == `MTG_ADDR_CMD && regWdata[0];
    endsequence
    sequence trigRise;
        $rose(trigPin) ##1 trigPin [*3];
    endsequence
    shot_send_a: assert property (shotWr |-> ##2 sendValid)
        else $error("single shot gave no send");
    reset_out_a: assert property ($fell(sys_rst) |-> !sendValid && !sendDup && regRdata == 32'h0000_0000)
        else $error("outputs not clear after reset");
    read_only_a: assert property (regRdata != 32'h0000_0000 |-> $past(regRd))
        else $error("read data without read");
    off_quiet_a: assert property (quiet_ff == 4'hF && (!ctrl_ff[2] || ctrl_ff[1:0] == 2'h0) |-> !sendValid)
        else $error("send while triggering off");
    dup_repeat_a: assert property (sendValid && sendDup |-> sendData == $past(sendData))
        else $error("resend carries new data");
    data_hold_a: assert property (!sendValid |-> $stable(sendData))
        else $error("send data moved between sends");
    edge_send_a: assert property ((ctrl_ff == 3'h5 && quiet_ff == 4'hF) ##0 trigRise |-> ##[0:8] sendValid)
        else $error("edge gave no send");
    level_stop_a: assert property ((ctrl_ff == 3'h6 && quiet_ff == 4'hF && !trigPin) [*8] |-> !sendValid)
        else $error("send while level low");
    demod_hold_a: assert property (!demodPresent [*2] |=> $stable(syncOutPin))
        else $error("sampling without demodulator");
endmodule
bind mtg_trigger_gate mtg_gate_sva #(.CHANNELS(CHANNELS), .WIDTH(WIDTH), .CHAIN_POS(CHAIN_POS)) mtg_gate_sva_i (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .trigPin(trigPin), .syncInPin(syncInPin), .syncOutPin(syncOutPin),
    .demodPresent(demodPresent), .convData(convData), .sendValid(sendValid), .sendData(sendData),
    .sendDup(sendDup));
`default_nettype wire

/* File: verif/mtg_far_side.sv */
// trigger source and upstream sync controller model
`timescale 1ns/1ns
`default_nettype none
module mtg_far_side
(
    // clock in, pins out
    input  wire logic clk_sys,
    output var  logic trigPin,
    output var  logic syncInPin
);
    // ***********
    // pin drivers
    // ***********
    initial
    begin
        trigPin   = 1'b0;
        syncInPin = 1'b0;
    end
    // trigger high for hi cycles, then low for lo cycles
    task automatic trigPulse(input int hi, input int lo);
        @(posedge clk_sys) trigPin <= 1'b1;
        repeat (hi) @(posedge clk_sys);
        trigPin <= 1'b0;
        repeat (lo) @(posedge clk_sys);
    endtask
    // upstream sync output toggling n times, still otherwise
    task automatic syncBurst(input int n);
        repeat (n)
        begin
            repeat (8) @(posedge clk_sys);
            syncInPin <= ~syncInPin;
        end
    endtask
endmodule
`default_nettype wire

/* File: verif/tb_measurement_trigger_gate.sv */
// self-checking bench for the trigger gate
`timescale 1ns/1ns
`default_nettype none
`include "mtg_consts.svh"
module tb_measurement_trigger_gate
    import mtg_pkg::*;
;
    // *****************
    // signals and tasks
    // *****************
    localparam int CH = 2;
    localparam int W  = 24;
    typedef struct {logic [3:0] a; logic [31:0] d;} mtg_row_t;
    mtg_row_t        rows [6] = '{'{4'h0, 32'h0000_0000}, '{4'h1, 32'h0000_0064}, '{4'h3, 32'h0000_0010},
                              '{4'h4, 32'h0000_0000}, '{4'h5, 32'h0000_0000}, '{4'h8, 32'h0000_0000}};
    logic            clk_sys, sys_rst, regWr, regRd, demodPresent, trigPin, syncInPin, syncOutPin;
    logic            sendValid, sendDup;
    logic [3:0]      regAddr;
    logic [31:0]     regWdata, regRdata, rd;
    logic [CH*W-1:0] convData, sendData;
    int              miscompares, checks, sendCnt, dupCnt, b, db;
    mtg_trigger_gate #(.CHANNELS(CH), .WIDTH(W), .CHAIN_POS(1)) mtg_trigger_gate_i (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
        .regRd(regRd), .regRdata(regRdata), .trigPin(trigPin), .syncInPin(syncInPin),
        .syncOutPin(syncOutPin), .demodPresent(demodPresent), .convData(convData),
        .sendValid(sendValid), .sendData(sendData), .sendDup(sendDup));
    mtg_far_side mtg_far_side_i (.clk_sys(clk_sys), .trigPin(trigPin), .syncInPin(syncInPin));
    // clock
    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // count sends and resends
    always @(posedge clk_sys)
    begin
        if (sendValid === 1'b1)
            sendCnt <= sendCnt + 1;
        if (sendValid === 1'b1 && sendDup === 1'b1)
            dupCnt <= dupCnt + 1;
    end
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wrReg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        regAddr  <= a;
        regWdata <= d;
        regWr    <= 1'b1;
        @(posedge clk_sys);
        regWr <= 1'b0;
    endtask
    task automatic rdReg(input logic [3:0] a);
        @(posedge clk_sys);
        regAddr <= a;
        regRd   <= 1'b1;
        @(posedge clk_sys);
        regRd <= 1'b0;
        #1 rd = regRdata;
    endtask
    task automatic finish_test;
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // watchdog
    initial
    begin
        repeat (6000) @(posedge clk_sys);
        miscompares++;
        finish_test();
    end
    // main sequence
    initial
    begin
        {sys_rst, demodPresent, regWr, regRd, regAddr, regWdata} = {2'h3, 38'h0};
        convData = 48'h1234_5678_9ABC;
        {miscompares, checks, sendCnt, dupCnt} = {4{32'h0000_0000}};
        repeat (8) @(posedge clk_sys);
        sys_rst <= 1'b0;
        foreach (rows[i])
        begin
            rdReg(rows[i].a);
            check(rd, rows[i].d);
        end
        $display("test reset values done");
        repeat (95) @(posedge clk_sys);
        // trigger while off must not send
        mtg_far_side_i.trigPulse(5, 20);
        wrReg(`MTG_ADDR_CMD, 32'h0000_0001);
        repeat (5) @(posedge clk_sys);
        check(sendCnt, 1);
        check(sendData, convData);
        rdReg(`MTG_ADDR_COUNT);
        check(rd, 1);
        $display("test single shot done");
        wrReg(`MTG_ADDR_RATE, 32'h0000_0003);
        wrReg(`MTG_ADDR_CTRL, 32'h0000_0005);
        b = sendCnt;
        repeat (3) mtg_far_side_i.trigPulse(5, 20);
        check(sendCnt - b, 3);
        wrReg(`MTG_ADDR_RATE, 32'h0000_00C8);
        {b, db} = {sendCnt, dupCnt};
        repeat (3) mtg_far_side_i.trigPulse(5, 7);
        repeat (10) @(posedge clk_sys);
        check(sendCnt - b, 3);
        check(dupCnt - db > 0, 1);
        $display("test edge mode done");
        wrReg(`MTG_ADDR_RATE, 32'h0000_0003);
        wrReg(`MTG_ADDR_CTRL, 32'h0000_0006);
        b = sendCnt;
        mtg_far_side_i.trigPulse(40, 12);
        check(sendCnt - b inside {[8:12]}, 1);
        b = sendCnt;
        repeat (40) @(posedge clk_sys);
        check(sendCnt - b, 0);
        $display("test level mode done");
        wrReg(`MTG_ADDR_CTRL, 32'h0000_0007);
        b = sendCnt;
        mtg_far_side_i.trigPulse(5, 40);
        check(sendCnt - b inside {[6:12]}, 1);
        mtg_far_side_i.trigPulse(5, 12);
        b = sendCnt;
        repeat (40) @(posedge clk_sys);
        check(sendCnt - b, 0);
        mtg_far_side_i.trigPulse(5, 20);
        wrReg(`MTG_ADDR_CTRL, 32'h0000_0006);
        wrReg(`MTG_ADDR_CTRL, 32'h0000_0007);
        repeat (8) @(posedge clk_sys);
        b = sendCnt;
        repeat (40) @(posedge clk_sys);
        check(sendCnt - b, 0);
        $display("test gate mode done");
        wrReg(`MTG_ADDR_CTRL, 32'h0000_0003);
        b = sendCnt;
        mtg_far_side_i.trigPulse(5, 20);
        wrReg(`MTG_ADDR_CMD, 32'h0000_0001);
        repeat (5) @(posedge clk_sys);
        check(sendCnt - b, 1);
        $display("test disabled done");
        mtg_far_side_i.syncBurst(10);
        rdReg(`MTG_ADDR_STATUS);
        check(rd[3], 1);
        repeat (300) @(posedge clk_sys);
        rdReg(`MTG_ADDR_STATUS);
        check(rd[3], 0);
        demodPresent <= 1'b0;
        rdReg(`MTG_ADDR_STATUS);
        check(rd[4], 0);
        b = syncOutPin;
        repeat (12) @(posedge clk_sys);
        check(syncOutPin, b);
        demodPresent <= 1'b1;
        $display("test sync and demod done");
        wrReg(`MTG_ADDR_CTRL, 32'h0000_0007);
        mtg_far_side_i.trigPulse(5, 5);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        rdReg(`MTG_ADDR_STATUS);
        check(rd, 32'h0000_0010);
        $display("test second reset done");
        finish_test();
    end
endmodule
`default_nettype wire
